// ### logic/lsp_link_status_regs.sv
`timescale 1ns/1ps
module lsp_link_status_regs
    import lsp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire lsp_link_in_t link_in,
    input wire lsp_bind_t bind_sel,
    output lsp_pd_out_t pd_out,
    output logic irq
);

    if (ADDR_W < LSP_ADDR_W_MIN || ADDR_W > LSP_ADDR_W_MAX) begin : g_chk
        $error("lsp_link_status_regs: ADDR_W out of range");
    end

    lsp_state_t st;
    lsp_state_t next_st;

    logic hit_status;
    logic hit_pd;
    logic hit_irq_stat;
    logic hit_irq_mask;
    logic hit_ctrl;

    logic [LSP_EV_N-1:0] ev_set;
    logic [LSP_EV_N-1:0] flag_clr;
    logic [LSP_EV_N-1:0] flag_q;
    logic [LSP_EV_N-1:0] irq_clr;
    logic [LSP_EV_N-1:0] irq_q;
    logic [7:0] status_word;

    assign hit_status = addr == ADDR_W'(LSP_OFS_LINK_STATUS);
    assign hit_pd = addr == ADDR_W'(LSP_OFS_CHAN_PD);
    assign hit_irq_stat = addr == ADDR_W'(LSP_OFS_IRQ_STATUS);
    assign hit_irq_mask = addr == ADDR_W'(LSP_OFS_IRQ_MASK);
    assign hit_ctrl = addr == ADDR_W'(LSP_OFS_LINK_CTRL);

    // Events; nothing fires while the link subsystem is powered off
    assign ev_set[LSP_EV_LMFC] = link_in.sysref && st.armed && !st.pd.link_off;
    assign ev_set[LSP_EV_REALIGN] = link_in.phase_shift && !st.pd.link_off;

    // Write-one-to-clear; a zero leaves the flag alone
    assign flag_clr[LSP_EV_LMFC] = wr && hit_status && wdata[LSP_ST_LMFC];
    assign flag_clr[LSP_EV_REALIGN] = wr && hit_status && wdata[LSP_ST_REALIGN];

    // Interrupt status clears on read
    assign irq_clr = {LSP_EV_N{rd && hit_irq_stat}};

    lsp_sticky #(
        .W(LSP_EV_N)
    ) u_flags (
        .clock(clock),
        .rst_n(rst_n),
        .set(ev_set),
        .clr(flag_clr),
        .q(flag_q)
    );

    lsp_sticky #(
        .W(LSP_EV_N)
    ) u_irq (
        .clock(clock),
        .rst_n(rst_n),
        .set(ev_set),
        .clr(irq_clr),
        .q(irq_q)
    );

    // Status image; reserved bits read zero, PLL lock reads zero while the link is off
    always_comb begin
        status_word = 8'h00;
        status_word[LSP_ST_SYNC] = link_in.sync_n;
        status_word[LSP_ST_REALIGN] = flag_q[LSP_EV_REALIGN];
        status_word[LSP_ST_LMFC] = flag_q[LSP_EV_LMFC];
        status_word[LSP_ST_PLL] = link_in.pll_locked && !st.pd.link_off;
    end

    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;

        // Register writes; status writes only reach the clear terms
        if (wr) begin
            if (hit_pd) begin
                // Taken as is; the encoder is expected off here
                next_st.chan_pd = wdata;
            end else if (hit_irq_mask) begin
                next_st.irq_mask = wdata[LSP_EV_N-1:0];
            end else if (hit_ctrl) begin
                next_st.enc_en = wdata[LSP_CTRL_ENC];
                next_st.armed = wdata[LSP_CTRL_ENC] && (st.armed || !st.enc_en);
            end
        end

        // First SYSREF after enabling consumes the arm
        if (ev_set[LSP_EV_LMFC]) begin
            next_st.armed = 1'b0;
        end

        // Register reads, data in the next cycle
        if (rd) begin
            if (hit_status) begin
                next_st.rdata = status_word;
            end else if (hit_pd) begin
                next_st.rdata = st.chan_pd;
            end else if (hit_irq_stat) begin
                next_st.rdata = {6'h00, irq_q};
            end else if (hit_irq_mask) begin
                next_st.rdata = {6'h00, st.irq_mask};
            end else if (hit_ctrl) begin
                next_st.rdata = {7'h00, st.enc_en};
            end else begin
                next_st.rdata = 8'h00;
            end
        end

        // Power-down outputs follow the new register contents
        next_st.pd.adc_a = next_st.chan_pd[LSP_PD_A];
        next_st.pd.adc_b = next_st.chan_pd[LSP_PD_B];
        next_st.pd.dig_a = bind_sel.dig_a_src ? next_st.chan_pd[LSP_PD_B]
                                              : next_st.chan_pd[LSP_PD_A];
        next_st.pd.dig_b = bind_sel.dig_b_src ? next_st.chan_pd[LSP_PD_B]
                                              : next_st.chan_pd[LSP_PD_A];
        next_st.pd.link_off = next_st.chan_pd[LSP_PD_A] && next_st.chan_pd[LSP_PD_B];
        next_st.pd.link_a_run = next_st.enc_en && !next_st.pd.link_off;
        next_st.pd.b_slots_undef = next_st.pd.link_a_run && next_st.pd.dig_b;

        // Arm is dropped while the LMFC is powered down
        if (next_st.pd.link_off) begin
            next_st.armed = 1'b0;
        end

        next_st.irq = |(irq_q & st.irq_mask);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.chan_pd <= LSP_RST_CHAN_PD;
            st.irq_mask <= LSP_RST_IRQ_MASK;
            st.enc_en <= LSP_RST_ENC;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign pd_out = st.pd;
    assign irq = st.irq;

    // Checks

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!rst_n);

    sequence status_rd_s;
        rd && hit_status;
    endsequence

    sequence enable_on_s;
        wr && hit_ctrl && wdata[LSP_CTRL_ENC] && !st.enc_en;
    endsequence

    sequence first_sysref_s;
        link_in.sysref && st.armed && !st.pd.link_off;
    endsequence

    sequence realign_ev_s;
        link_in.phase_shift && !st.pd.link_off;
    endsequence

    sequence realign_clr_s;
        wr && hit_status && wdata[LSP_ST_REALIGN];
    endsequence

    sequence lmfc_clr_s;
        wr && hit_status && wdata[LSP_ST_LMFC];
    endsequence

    sequence pd_write_s;
        wr && hit_pd;
    endsequence

    sequence irq_rd_s;
        rd && hit_irq_stat;
    endsequence

    sequence enable_off_s;
        wr && hit_ctrl && !wdata[LSP_CTRL_ENC];
    endsequence

    sequence unmapped_rd_s;
        rd && !hit_status && !hit_pd && !hit_irq_stat && !hit_irq_mask && !hit_ctrl;
    endsequence

    sync_live_read_a: assert property (
        status_rd_s |=> rdata[LSP_ST_SYNC] == $past(link_in.sync_n))
        else $error("sync level not returned in status");

    realign_sets_a: assert property (
        realign_ev_s
        |=> flag_q[LSP_EV_REALIGN] && irq_q[LSP_EV_REALIGN])
        else $error("realign flag not set by phase shift");

    realign_holds_a: assert property (
        flag_q[LSP_EV_REALIGN] && !(wr && hit_status && wdata[LSP_ST_REALIGN])
        |=> flag_q[LSP_EV_REALIGN])
        else $error("realign flag lost without a one written");

    lmfc_arm_set_a: assert property (
        first_sysref_s |=> flag_q[LSP_EV_LMFC] && irq_q[LSP_EV_LMFC] && !st.armed)
        else $error("first sysref after enable did not set lmfc flag");

    lmfc_unarmed_a: assert property (
        !st.armed && !flag_q[LSP_EV_LMFC] |=> !flag_q[LSP_EV_LMFC])
        else $error("lmfc flag set without an armed sysref");

    w1c_zero_a: assert property (
        wr && hit_status && !wdata[LSP_ST_LMFC] && flag_q[LSP_EV_LMFC]
        |=> flag_q[LSP_EV_LMFC])
        else $error("writing zero cleared the lmfc flag");

    pll_lock_read_a: assert property (
        status_rd_s |=> rdata[LSP_ST_PLL] == $past(link_in.pll_locked && !st.pd.link_off))
        else $error("pll lock bit wrong");

    chan_a_pd_a: assert property (
        wr && hit_pd |=> pd_out.adc_a == $past(wdata[LSP_PD_A])
            && (pd_out.dig_a == $past(bind_sel.dig_a_src ? wdata[LSP_PD_B] : wdata[LSP_PD_A])))
        else $error("channel A power-down not applied");

    chan_b_pd_a: assert property (
        wr && hit_pd |=> pd_out.adc_b == $past(wdata[LSP_PD_B])
            && (pd_out.dig_b == $past(bind_sel.dig_b_src ? wdata[LSP_PD_B] : wdata[LSP_PD_A])))
        else $error("channel B power-down not applied");

    link_shutdown_a: assert property (
        pd_out.adc_a && pd_out.adc_b |-> pd_out.link_off && !pd_out.link_a_run && !st.armed)
        else $error("link not shut with both converters off");

    link_a_keeps_a: assert property (
        st.enc_en && !pd_out.link_off && pd_out.dig_b |-> pd_out.link_a_run && pd_out.b_slots_undef)
        else $error("link A stopped with B digital channel off");

    irq_follow_a: assert property (
        (irq_q & st.irq_mask) != '0 |=> irq)
        else $error("unmasked event did not raise interrupt");

    enable_arms_a: assert property (
        enable_on_s ##0 !st.pd.link_off
        |=> st.armed && st.enc_en)
        else $error("encoder enable did not arm lmfc capture");

    enable_off_disarm_a: assert property (
        enable_off_s |=> !st.armed && !st.enc_en && !pd_out.link_a_run)
        else $error("encoder disable left lmfc capture armed");

    realign_clear_a: assert property (
        realign_clr_s ##0 !(link_in.phase_shift && !st.pd.link_off)
        |=> !flag_q[LSP_EV_REALIGN])
        else $error("writing one did not clear realign flag");

    lmfc_clear_a: assert property (
        lmfc_clr_s ##0 !(link_in.sysref && st.armed && !st.pd.link_off)
        |=> !flag_q[LSP_EV_LMFC])
        else $error("writing one did not clear lmfc flag");

    status_no_store_a: assert property (
        wr && hit_status
        |=> st.chan_pd == $past(st.chan_pd) && st.irq_mask == $past(st.irq_mask)
            && st.enc_en == $past(st.enc_en))
        else $error("status write changed another register");

    reserved_zero_a: assert property (
        status_rd_s |=> rdata[7:6] == 2'h0 && rdata[1:0] == 2'h0)
        else $error("reserved status bits not zero");

    off_no_events_a: assert property (
        st.pd.link_off
        |=> (flag_q & ~$past(flag_q)) == '0 && (irq_q & ~$past(irq_q)) == '0)
        else $error("event taken while link powered down");

    pd_hold_a: assert property (
        !(wr && hit_pd) |=> st.chan_pd == $past(st.chan_pd))
        else $error("power-down register changed without a write");

    pd_store_a: assert property (
        pd_write_s |=> st.chan_pd == $past(wdata))
        else $error("power-down write not stored");

    pd_readback_a: assert property (
        rd && hit_pd |=> rdata == $past(st.chan_pd))
        else $error("power-down register read back wrong");

    pd_bind_a: assert property (
        pd_out.dig_a == ($past(bind_sel.dig_a_src) ? pd_out.adc_b : pd_out.adc_a)
        && pd_out.dig_b == ($past(bind_sel.dig_b_src) ? pd_out.adc_b : pd_out.adc_a))
        else $error("digital channel not following its bound converter");

    pll_off_a: assert property (
        status_rd_s ##0 st.pd.link_off |=> !rdata[LSP_ST_PLL])
        else $error("pll lock shown while link powered down");

    link_on_a: assert property (
        !(pd_out.adc_a && pd_out.adc_b) |-> !pd_out.link_off)
        else $error("link powered down with a converter on");

    mask_write_a: assert property (
        wr && hit_irq_mask |=> st.irq_mask == $past(wdata[LSP_EV_N-1:0]))
        else $error("interrupt mask write not stored");

    irq_rd_data_a: assert property (
        irq_rd_s |=> rdata == {6'h00, $past(irq_q)})
        else $error("interrupt status read wrong");

    irq_read_clear_a: assert property (
        irq_rd_s ##0 !(|ev_set) |=> irq_q == '0)
        else $error("interrupt status not cleared by read");

    irq_quiet_a: assert property (
        (irq_q & st.irq_mask) == '0 |=> !irq)
        else $error("interrupt raised with no unmasked event");

    unmapped_read_a: assert property (
        unmapped_rd_s |=> rdata == 8'h00)
        else $error("unmapped read returned data");

    rdata_idle_a: assert property (
        !rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");

endmodule

// ### logic/lsp_pkg.sv
package lsp_pkg;

    localparam int LSP_ADDR_W_MIN = 10;
    localparam int LSP_ADDR_W_MAX = 12;
    localparam int LSP_DATA_W = 8;

    // Register offsets
    localparam logic [11:0] LSP_OFS_LINK_STATUS = 12'h208;
    localparam logic [11:0] LSP_OFS_CHAN_PD = 12'h209;
    localparam logic [11:0] LSP_OFS_IRQ_STATUS = 12'h2F0;
    localparam logic [11:0] LSP_OFS_IRQ_MASK = 12'h2F1;
    localparam logic [11:0] LSP_OFS_LINK_CTRL = 12'h2F2;

    // Link status field positions
    localparam int LSP_ST_SYNC = 5;
    localparam int LSP_ST_REALIGN = 4;
    localparam int LSP_ST_LMFC = 3;
    localparam int LSP_ST_PLL = 2;

    // Channel power-down field positions
    localparam int LSP_PD_A = 0;
    localparam int LSP_PD_B = 1;

    // Link control field position
    localparam int LSP_CTRL_ENC = 0;

    // Event index in sticky flag vectors and in the interrupt registers
    localparam int LSP_EV_LMFC = 0;
    localparam int LSP_EV_REALIGN = 1;
    localparam int LSP_EV_N = 2;

    // Reset values
    localparam logic [7:0] LSP_RST_CHAN_PD = 8'h00;
    localparam logic [1:0] LSP_RST_IRQ_MASK = 2'h0;
    localparam logic LSP_RST_ENC = 1'b0;

    typedef struct packed {
        logic sync_n;
        logic sysref;
        logic phase_shift;
        logic pll_locked;
    } lsp_link_in_t;

    // Source converter of each digital channel: 0 = channel A, 1 = channel B
    typedef struct packed {
        logic dig_a_src;
        logic dig_b_src;
    } lsp_bind_t;

    typedef struct packed {
        logic adc_a;
        logic adc_b;
        logic dig_a;
        logic dig_b;
        logic link_off;
        logic link_a_run;
        logic b_slots_undef;
    } lsp_pd_out_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] chan_pd;
        logic [1:0] irq_mask;
        logic enc_en;
        logic armed;
        lsp_pd_out_t pd;
        logic irq;
    } lsp_state_t;

endpackage

// ### logic/lsp_sticky.sv
`timescale 1ns/1ps
module lsp_sticky #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] q;
    } lsp_sticky_st_t;

    lsp_sticky_st_t st;
    lsp_sticky_st_t next_st;

    if (W < 1) begin : g_chk
        $error("lsp_sticky needs W of at least one");
    end

    // Set wins over a clear in the same cycle
    always_comb begin
        next_st = st;
        for (int i = 0; i < W; i++) begin
            if (set[i]) begin
                next_st.q[i] = 1'b1;
            end else if (clr[i]) begin
                next_st.q[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

    set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
        |set |=> (q & $past(set)) == $past(set))
        else $error("sticky bit lost its set");

endmodule

// ### sim/lsp_rx_model.sv
`timescale 1ns/1ps
module lsp_rx_model
    import lsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic want_sync,
    input wire logic slow,
    input wire logic sysref_go,
    input wire logic shift_go,
    input wire logic lock,
    output lsp_link_in_t link_in
);
    logic [2:0] wait_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            link_in <= '0;
            wait_cnt <= 3'h0;
        end else begin
            // Release of sync request after a short or a long settle
            if (want_sync) begin
                link_in.sync_n <= 1'b0;
                wait_cnt <= slow ? 3'h4 : 3'h0;
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end else begin
                link_in.sync_n <= 1'b1;
            end
            link_in.sysref <= sysref_go;
            link_in.phase_shift <= shift_go;
            link_in.pll_locked <= lock;
        end
    end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import lsp_pkg::*;
;
    logic clock, rst_n, wr, rd, irq, want_sync, slow, sysref_go, shift_go, lock;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, d, v;
    lsp_link_in_t link_in;
    lsp_bind_t bind_sel;
    lsp_pd_out_t pd_out;
    int n_mismatch = 0;
    int compares = 0;

    lsp_link_status_regs #(.ADDR_W(12)) u_lsp_link_status_regs (.clock(clock), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_in(link_in), .bind_sel(bind_sel),
        .pd_out(pd_out), .irq(irq));
    lsp_rx_model u_lsp_rx_model (.clock(clock), .rst_n(rst_n), .want_sync(want_sync), .slow(slow),
        .sysref_go(sysref_go), .shift_go(shift_go), .lock(lock), .link_in(link_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] dat);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= dat;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [7:0] dat);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        dat = rdata;
    endtask

    // One event from the receiver side, then time for flag and irq
    task automatic pulse(input logic sr);
        @(posedge clock);
        if (sr) begin
            sysref_go <= 1'b1;
        end else begin
            shift_go <= 1'b1;
        end
        @(posedge clock);
        sysref_go <= 1'b0;
        shift_go <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    function automatic logic [7:0] exp_stat(logic s, logic r, logic l, logic k, logic off);
        return {2'h0, s, r, l, k & ~off, 2'h0};
    endfunction

    function automatic logic [7:0] exp_pd(logic [1:0] pd, lsp_bind_t b);
        lsp_pd_out_t e;
        e.adc_a = pd[0];
        e.adc_b = pd[1];
        e.dig_a = b.dig_a_src ? pd[1] : pd[0];
        e.dig_b = b.dig_b_src ? pd[1] : pd[0];
        e.link_off = &pd;
        e.link_a_run = ~e.link_off;
        e.b_slots_undef = e.link_a_run & e.dig_b;
        return {1'b0, e};
    endfunction

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        {rst_n, wr, rd, slow, sysref_go, shift_go, lock} = '0;
        {addr, wdata, bind_sel} = '0;
        want_sync = 1'b1;
        void'($urandom(67933));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(LSP_OFS_CHAN_PD, d);
        chk(d, LSP_RST_CHAN_PD);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            want_sync <= 1'($urandom);
            slow <= 1'($urandom);
            lock <= (i == 5) ? 1'b1 : 1'($urandom);
            repeat (8) @(posedge clock);
            rd_reg(LSP_OFS_LINK_STATUS, d);
            chk(d, exp_stat(~want_sync, 1'b0, 1'b0, lock, 1'b0));
        end
        @(posedge clock);
        want_sync <= 1'b0;
        wr_reg(LSP_OFS_IRQ_MASK, 8'h03);
        pulse(1'b1);
        rd_reg(LSP_OFS_LINK_STATUS, d);
        chk(d, exp_stat(1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
        wr_reg(LSP_OFS_LINK_CTRL, 8'h01);
        pulse(1'b1);
        wr_reg(LSP_OFS_LINK_STATUS, 8'h00);
        wr_reg(LSP_OFS_LINK_STATUS, 8'hE7);
        rd_reg(LSP_OFS_LINK_STATUS, d);
        chk(d, exp_stat(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
        chk({7'h00, irq}, 8'h01);
        rd_reg(LSP_OFS_IRQ_STATUS, d);
        chk(d, 8'h01);
        rd_reg(LSP_OFS_IRQ_STATUS, d);
        chk(d, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr_reg(LSP_OFS_LINK_STATUS, 8'h08);
        // Second sysref after enable must not set the flag again
        pulse(1'b1);
        rd_reg(LSP_OFS_LINK_STATUS, d);
        chk(d, exp_stat(1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
        pulse(1'b0);
        rd_reg(LSP_OFS_LINK_STATUS, d);
        chk(d, exp_stat(1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
        rd_reg(LSP_OFS_IRQ_STATUS, d);
        chk(d, 8'h02);
        wr_reg(LSP_OFS_LINK_STATUS, 8'h10);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h03 : 8'($urandom);
            if (i != 0 && &v[1:0]) v[LSP_PD_B] = 1'b0;
            wr_reg(LSP_OFS_LINK_CTRL, 8'h00);
            @(posedge clock);
            bind_sel <= 2'($urandom);
            wr_reg(LSP_OFS_CHAN_PD, v);
            wr_reg(LSP_OFS_LINK_CTRL, 8'h01);
            repeat (3) @(posedge clock);
            #1;
            chk({1'b0, pd_out}, exp_pd(v[1:0], bind_sel));
            rd_reg(LSP_OFS_CHAN_PD, d);
            chk(d, v);
            if (&v[1:0]) begin
                pulse(1'b1);
                pulse(1'b0);
            end
            rd_reg(LSP_OFS_LINK_STATUS, d);
            chk(d, exp_stat(1'b1, 1'b0, 1'b0, 1'b1, &v[1:0]));
        end
        wr_reg(12'h3FF, 8'hFF);
        rd_reg(12'h3FF, d);
        chk(d, 8'h00);
        tally_and_finish();
    end
endmodule
